// ---- dv/scpc_ctrl_tb.sv ----
// self-checking bench for the system clock prescaler controller
`timescale 1ns/1ps
module scpc_ctrl_tb;
   // bus, straps, power and design outputs
   logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, irq_ack_i;
   logic        div_by_eight_fuse_i, pll_lock_i, sleep_i, adc_src_pll_i;
   logic [9:0]  adr_i;
   logic [3:0]  sel_i;
   logic [31:0] dat_i, dat_o;
   logic [1:0]  sleep_mode_i;
   logic [7:0]  trim_a, trim_b, rd;
   logic        cpu_en, io_en, fl_en, adc_en, pin, pll_run, osc_run, irq;
   int          failures, check_count, p, t, io, cpu;

   scpc_ctrl u_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
      .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
      .div_by_eight_fuse_i(div_by_eight_fuse_i), .trim_factory_a_i(8'h5a), .trim_factory_b_i(8'ha5),
      .pll_lock_i(pll_lock_i), .sleep_i(sleep_i), .sleep_mode_i(sleep_mode_i),
      .adc_src_pll_i(adc_src_pll_i), .irq_ack_i(irq_ack_i), .cpu_clk_en_o(cpu_en), .io_clk_en_o(io_en),
      .flash_clk_en_o(fl_en), .adc_clk_en_o(adc_en), .clock_out_pin_o(pin), .trim_value_a_o(trim_a),
      .trim_value_b_o(trim_b), .pll_run_o(pll_run), .slow_osc_run_o(osc_run), .lock_change_irq_o(irq));

   // 10 MHz clock
   initial begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end

   task results;
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : results

   task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %0t %s got %0h exp %0h", $time, msg, got, exp);
      end
   endtask : chk

   task wait_clk(input int n);
      repeat (n) @(posedge clk_i);
   endtask : wait_clk

   // one classic cycle; ack is looked at with its pre-edge value
   task xfer(input logic [7:0] idx, input logic w, input logic [7:0] wd);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i  <= w;
      adr_i <= {idx, 2'h0};
      dat_i <= {24'h0, wd};
      sel_i <= 4'h1;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_o !== 1'b1 && n < 20);
      rd = dat_o[7:0];
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      we_i  <= 1'b0;
      if (ack_o !== 1'b1) begin
         failures++;
         $display("[FAIL] %0t bus timeout", $time);
         results();
      end
   endtask : xfer

   task wr(input logic [7:0] idx, input logic [7:0] d);
      xfer(idx, 1'b1, d);
   endtask : wr

   task rdc(input logic [7:0] idx, input logic [7:0] exp);
      xfer(idx, 1'b0, 8'h00);
      chk({24'h0, rd}, {24'h0, exp}, "register read");
   endtask : rdc

   // cycles between two enable pulses, bounded
   task period(input logic adc, output int q);
      int n;
      n = 0;
      q = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while ((adc ? adc_en : cpu_en) !== 1'b1 && n < 100);
      do begin
         @(posedge clk_i);
         q++;
      end while ((adc ? adc_en : cpu_en) !== 1'b1 && q < 100);
      if (n >= 100 || q >= 100) begin
         failures++;
         $display("[FAIL] %0t enable pulse timeout", $time);
         results();
      end
   endtask : period

   // pin toggles, io pulses and cpu pulses over n cycles
   task count(input int n);
      logic last;
      last = pin;
      t = 0;
      io = 0;
      cpu = 0;
      repeat (n) begin
         @(posedge clk_i);
         t += (pin !== last);
         io += (io_en === 1'b1);
         cpu += (cpu_en === 1'b1 && fl_en === 1'b1);
         last = pin;
      end
   endtask : count

   task set_div(input logic [1:0] s);
      // select follows the unlock within the window
      // no interrupt ack is driven between the two writes
      wr(8'h61, 8'h80);
      wr(8'h61, {6'h0, s});
   endtask : set_div

   task t_reset;
      rdc(8'h55, 8'h00);
      rdc(8'h61, 8'h00);
      rdc(8'h66, 8'h5a);
      rdc(8'h67, 8'ha5);
      rdc(8'hd8, 8'h00);
      rdc(8'h10, 8'h00);
      chk(trim_b, 8'ha5, "trim b pin");
      period(1'b0, p);
      chk(p, 2, "unlocked period");
      wr(8'h55, 8'hff);
      rdc(8'h55, 8'h20);
      wr(8'h55, 8'h00);
      wr(8'h61, 8'h7e);
      rdc(8'h61, 8'h00);
      wr(8'hd8, 8'hcc);
      rdc(8'hd8, 8'h00);
   endtask : t_reset

   task t_lock;
      wr(8'hd8, 8'h01);
      pll_lock_i <= 1'b1;
      wait_clk(6);
      rdc(8'hd8, 8'h13);
      chk(irq, 1'b1, "irq raised");
      wr(8'hd8, 8'h03);
      rdc(8'hd8, 8'h11);
      chk(irq, 1'b0, "irq cleared");
      wr(8'hd8, 8'h00);
      pll_lock_i <= 1'b0;
      wait_clk(6);
      chk(irq, 1'b0, "irq masked");
      rdc(8'hd8, 8'h02);
      irq_ack_i <= 1'b1;
      @(posedge clk_i);
      irq_ack_i <= 1'b0;
      wait_clk(2);
      rdc(8'hd8, 8'h00);
      pll_lock_i <= 1'b1;
      wait_clk(6);
      wr(8'hd8, 8'h02);
      rdc(8'hd8, 8'h10);
   endtask : t_lock

   task t_ratio;
      for (int s = 0; s < 4; s++) begin
         set_div(s[1:0]);
         rdc(8'h61, {6'h0, s[1:0]});
         period(1'b0, p);
         period(1'b0, p);
         chk(p, 1 << s, "system period");
      end
      set_div(2'h0);
   endtask : t_ratio

   task t_guard;
      wr(8'h61, 8'h81);
      wr(8'h61, 8'h02);
      rdc(8'h61, 8'h00);
      wr(8'h61, 8'h80);
      rdc(8'h61, 8'h80);
      wait_clk(12);
      rdc(8'h61, 8'h00);
      wr(8'h61, 8'h02);
      rdc(8'h61, 8'h00);
      // rewrite must not stretch the window past four ticks
      wr(8'h61, 8'h80);
      wr(8'h61, 8'h80);
      wr(8'h61, 8'h02);
      rdc(8'h61, 8'h00);
      // at divide by 8 the window is long enough to see a rewrite leave it open
      set_div(2'h3);
      wr(8'h61, 8'h80);
      wr(8'h61, 8'h80);
      rdc(8'h61, 8'h83);
      wr(8'h61, 8'h00);
      rdc(8'h61, 8'h00);
   endtask : t_guard

   task t_trim;
      wr(8'h66, 8'h3c);
      rdc(8'h66, 8'h5a);
      wr(8'h68, 8'hd8);
      wr(8'h66, 8'h3c);
      rdc(8'h66, 8'h3c);
      chk(trim_a, 8'h3c, "trim a pin");
      wr(8'h67, 8'h11);
      rdc(8'h67, 8'ha5);
   endtask : t_trim

   task t_clkout;
      wr(8'h55, 8'h20);
      // let the pin reach its steady toggling before counting
      wait_clk(2);
      count(16);
      chk(t, 16, "pin toggles div1");
      chk(io, 16, "io pulses");
      chk(cpu, 16, "cpu and flash pulses");
      set_div(2'h1);
      wait_clk(4);
      count(16);
      chk(t, 8, "pin toggles div2");
   endtask : t_clkout

   task t_sleep;
      sleep_mode_i <= 2'b00;
      sleep_i      <= 1'b1;
      wait_clk(3);
      count(16);
      chk(t, 0, "pin idle");
      chk(cpu, 0, "cpu stopped");
      chk(io, 8, "io runs in idle");
      sleep_mode_i <= 2'b10;
      wait_clk(3);
      count(8);
      chk(t, 0, "pin power-down");
      chk({pll_run, osc_run}, 2'b00, "power-down stops");
      wr(8'hd8, 8'h20);
      wait_clk(3);
      chk({pll_run, osc_run}, 2'b11, "override power-down");
      sleep_mode_i <= 2'b11;
      wait_clk(3);
      chk(pll_run, 1'b1, "override power-save");
      wr(8'hd8, 8'h00);
      wait_clk(3);
      chk(pll_run, 1'b0, "power-save stop");
      sleep_i <= 1'b0;
      wr(8'h55, 8'h00);
      wait_clk(3);
      chk(pin, 1'b0, "pin disabled");
   endtask : t_sleep

   task t_adc;
      adc_src_pll_i <= 1'b1;
      period(1'b1, p);
      period(1'b1, p);
      chk(p, 28, "adc period");
      adc_src_pll_i <= 1'b0;
   endtask : t_adc

   task t_fuse;
      div_by_eight_fuse_i <= 1'b1;
      rst_i <= 1'b1;
      wait_clk(2);
      rst_i <= 1'b0;
      wait_clk(4);
      rdc(8'h61, 8'h03);
      rdc(8'h66, 8'h5a);
      set_div(2'h1);
      rdc(8'h61, 8'h01);
   endtask : t_fuse

   // main sequence
   initial begin
      {cyc_i, stb_i, we_i, irq_ack_i, sleep_i, adc_src_pll_i} = 6'h0;
      {div_by_eight_fuse_i, pll_lock_i} = 2'h0;
      {adr_i, sel_i, dat_i, sleep_mode_i} = '0;
      failures = 0;
      check_count = 0;
      rst_i = 1'b1;
      wait_clk(16);
      rst_i <= 1'b0;
      wait_clk(2);
      t_reset();
      t_lock();
      t_ratio();
      t_guard();
      t_trim();
      t_clkout();
      t_sleep();
      t_adc();
      t_fuse();
      results();
   end
endmodule : scpc_ctrl_tb

// ---- rtl/scpc_ctrl.sv ----
// system clock prescaler controller: prescaler, clock out, adc divider, trims and pll status
//
// Notes on behaviour
// - select field divides the source clock by 1, 2, 4 or 8.
// - prescaled clock drives cpu, io and flash clock enables.
// - division changes are glitch free, never faster than old or new.
// - new ratio active between T1+T2 and T1+2*T2, two edges meanwhile.
// - prescaler is a counter on the undivided clock, not readable.
// - change enable sets only on a write of exactly bit 7 alone.
// - change enable clears after four cycles or on a select write.
// - rewriting change enable neither restarts the timeout nor clears it.
// - select loads 00, or 11 when the divide-by-eight fuse is programmed.
// - any select value is accepted regardless of the fuse.
// - clock out enable drives cpu clock divided by 2 on the pin.
// - clock out pin stops toggling in every sleep mode.
// - adc clock is the pll clock divided by 28 when selected.
// - both trim registers load factory values during reset.
// - trim registers are guarded by a timed unlock sequence.
// - lock status in bit 4; unlocked pll output is halved for the prescaler, not for the adc.
// - lock change flag sets on any lock edge, cleared by one or ack.
// - interrupt request only while enable and flag are both set.
// - sleep override bit keeps pll on in power-save and power-down.
// - reserved bits read zero and ignore writes.
// - with override set, slow osc and pll run in power-down.
// - the pll clock, fed by the slow osc, is the prescaler source.
//
// The Wishbone interface to the registers was decided locally.
`timescale 1ns/1ps
module scpc_ctrl (
   // clock (undivided pll clock) and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // wishbone classic slave
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [9:0]  adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   output logic [31:0]      dat_o,
   output logic             ack_o,
   // straps and factory data, static from the fuse block
   input  wire logic        div_by_eight_fuse_i,
   input  wire logic [7:0]  trim_factory_a_i,
   input  wire logic [7:0]  trim_factory_b_i,
   // pll and power management
   input  wire logic        pll_lock_i,
   input  wire logic        sleep_i,
   input  wire logic [1:0]  sleep_mode_i,
   input  wire logic        adc_src_pll_i,
   input  wire logic        irq_ack_i,
   // clock enables and pin
   output logic             cpu_clk_en_o,
   output logic             io_clk_en_o,
   output logic             flash_clk_en_o,
   output logic             adc_clk_en_o,
   output logic             clock_out_pin_o,
   // analog controls and interrupt
   output logic [7:0]       trim_value_a_o,
   output logic [7:0]       trim_value_b_o,
   output logic             pll_run_o,
   output logic             slow_osc_run_o,
   output logic             lock_change_irq_o
);
   // ---------------- bus decode ----------------
   logic       ack;
   logic [7:0] rd_byte;
   wire  [7:0] idx      = adr_i[9:2];
   wire        req      = cyc_i & stb_i;
   wire        wr_take  = req & we_i & ack & sel_i[0];
   wire  [7:0] wdat     = dat_i[7:0];
   wire        hit_mcu  = (idx == scpc_pkg::IDX_MCU_CONTROL);
   wire        hit_clk  = (idx == scpc_pkg::IDX_CLOCK_PRESC);
   wire        hit_ta   = (idx == scpc_pkg::IDX_TRIM_A);
   wire        hit_tb   = (idx == scpc_pkg::IDX_TRIM_B);
   wire        hit_tu   = (idx == scpc_pkg::IDX_TRIM_UNLOCK);
   wire        hit_pll  = (idx == scpc_pkg::IDX_PLL_CTRL_STAT);
   wire        wr_mcu   = wr_take & hit_mcu;
   wire        wr_clk   = wr_take & hit_clk;
   wire        wr_pll   = wr_take & hit_pll;

   // answer one cycle after the request, drop ack the cycle after
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack   <= 1'b0;
         dat_o <= 32'h0000_0000;
      end else begin
         ack   <= req & ~ack;
         dat_o <= {24'h00_0000, rd_byte};
      end
   end
   assign ack_o = ack;

   // ---------------- lock synchroniser ----------------
   logic lock_meta;
   logic lock_q;
   logic lock_prev;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         lock_meta <= 1'b0;
         lock_q    <= 1'b0;
         lock_prev <= 1'b0;
      end else begin
         lock_meta <= pll_lock_i;
         lock_q    <= lock_meta;
         lock_prev <= lock_q;
      end
   end
   wire lock_edge = lock_q ^ lock_prev;

   // ---------------- base clock ----------------
   // halve when unlocked
   logic half_phase;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         half_phase <= 1'b0;
      end else begin
         half_phase <= ~half_phase;
      end
   end
   // pll clock is the prescaler source
   wire base_tick = lock_q | half_phase;

   // ---------------- prescaler ----------------
   logic [1:0] presc_sel;
   logic [1:0] active_sel;
   logic [2:0] ripple;
   logic       fuse_done;
   wire  [2:0] div_mask = (active_sel == 2'h0) ? 3'h0 :
                          (active_sel == 2'h1) ? 3'h1 :
                          (active_sel == 2'h2) ? 3'h3 : 3'h7;
   // ratio taken from the active select
   wire        sys_tick = base_tick & ((ripple & div_mask) == div_mask);
   wire        switch_now = sys_tick & (presc_sel != active_sel);

   // ripple counter on the undivided clock, never exposed
   // new ratio is adopted only at an old period boundary
   // counter restarts so the next edge comes one new period later
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ripple <= 3'h0;
      end else if (switch_now) begin
         ripple <= 3'h0;
      end else if (base_tick) begin
         ripple <= ripple + 3'h1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         active_sel <= scpc_pkg::SEL_DIV1;
      end else if (switch_now || !fuse_done) begin
         active_sel <= presc_sel;
      end
   end

   // ---------------- change enable window ----------------
   logic       change_en;
   logic [2:0] change_cnt;
   wire        unlock_wr = wr_clk & (wdat == scpc_pkg::PRESC_UNLOCK_VAL);
   wire        select_wr = wr_clk & change_en & ~wdat[scpc_pkg::BIT_PRESC_CHANGE_EN];
   wire        window_end = change_en & sys_tick &
                            (change_cnt == scpc_pkg::CHANGE_WINDOW_CYC - 3'h1);

   // only the exact unlock value opens the window
   // a repeated unlock inside the window changes nothing
   // close on timeout or on the select write
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         change_en  <= 1'b0;
         change_cnt <= 3'h0;
      end else if (select_wr || window_end) begin
         change_en  <= 1'b0;
         change_cnt <= 3'h0;
      end else if (unlock_wr && !change_en) begin
         change_en  <= 1'b1;
         change_cnt <= 3'h0;
      end else if (change_en && sys_tick) begin
         change_cnt <= change_cnt + 3'h1;
      end
   end

   // fuse picks the select value after reset
   // any select value is accepted once unlocked
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         presc_sel <= scpc_pkg::SEL_DIV1;
         fuse_done <= 1'b0;
      end else if (!fuse_done) begin
         presc_sel <= div_by_eight_fuse_i ? scpc_pkg::SEL_DIV8 : scpc_pkg::SEL_DIV1;
         fuse_done <= 1'b1;
      end else if (select_wr) begin
         presc_sel <= wdat[1:0];
      end
   end

   // ---------------- control registers ----------------
   logic [7:0] mcu_control;
   logic       pll_sleep_override;
   logic       lock_change_irq_enable;
   logic       lock_change_flag;
   wire        clock_out_enable = mcu_control[scpc_pkg::BIT_CLOCK_OUT_ENABLE];
   wire        flag_clear = irq_ack_i | (wr_pll & wdat[scpc_pkg::BIT_LOCK_CHANGE_FLAG]);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mcu_control            <= scpc_pkg::RST_MCU_CONTROL;
         pll_sleep_override     <= 1'b0;
         lock_change_irq_enable <= 1'b0;
      end else begin
         if (wr_mcu) begin
            mcu_control <= wdat & scpc_pkg::MASK_MCU_CONTROL;
         end
         if (wr_pll) begin
            pll_sleep_override     <= wdat[scpc_pkg::BIT_PLL_SLEEP_OVR];
            lock_change_irq_enable <= wdat[scpc_pkg::BIT_LOCK_CHANGE_IE];
         end
      end
   end

   // any lock edge sets the flag; set beats a same-cycle clear
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         lock_change_flag <= 1'b0;
      end else if (lock_edge) begin
         lock_change_flag <= 1'b1;
      end else if (flag_clear) begin
         lock_change_flag <= 1'b0;
      end
   end

   // ---------------- trim registers ----------------
   logic       trim_open;
   logic [2:0] trim_cnt;
   wire        trim_key_wr = wr_take & hit_tu & (wdat == scpc_pkg::TRIM_UNLOCK_KEY);
   wire        trim_wr_a   = wr_take & hit_ta & trim_open;
   wire        trim_wr_b   = wr_take & hit_tb & trim_open;

   // key write opens a short window; any trim write closes it
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         trim_open <= 1'b0;
         trim_cnt  <= 3'h0;
      end else if (trim_wr_a || trim_wr_b ||
                   (trim_open && sys_tick && trim_cnt == scpc_pkg::CHANGE_WINDOW_CYC - 3'h1)) begin
         trim_open <= 1'b0;
         trim_cnt  <= 3'h0;
      end else if (trim_key_wr && !trim_open) begin
         trim_open <= 1'b1;
         trim_cnt  <= 3'h0;
      end else if (trim_open && sys_tick) begin
         trim_cnt <= trim_cnt + 3'h1;
      end
   end

   // factory values load during reset (synchronous load)
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         trim_value_a_o <= trim_factory_a_i;
         trim_value_b_o <= trim_factory_b_i;
      end else begin
         if (trim_wr_a) begin
            trim_value_a_o <= wdat;
         end
         if (trim_wr_b) begin
            trim_value_b_o <= wdat;
         end
      end
   end

   // ---------------- read mux ----------------
   // reserved bits read zero; ripple state has no read path
   // lock state shown in bit 4
   wire [7:0] rd_pll = {2'h0, pll_sleep_override, lock_q, 2'h0,
                        lock_change_flag, lock_change_irq_enable};
   wire [7:0] rd_clk = {change_en, 5'h00, presc_sel};
   assign rd_byte = hit_mcu ? mcu_control :
                    hit_clk ? rd_clk :
                    hit_ta  ? trim_value_a_o :
                    hit_tb  ? trim_value_b_o :
                    hit_tu  ? {7'h00, trim_open} :
                    hit_pll ? rd_pll : 8'h00;

   // ---------------- sleep decode ----------------
   wire in_pdown = sleep_i & (sleep_mode_i == scpc_pkg::SCPC_POWER_DOWN);
   wire in_psave = sleep_i & (sleep_mode_i == scpc_pkg::SCPC_POWER_SAVE);

   // ---------------- clock outputs ----------------
   wire adc_tick;
   scpc_tick_div #(
      .DIVIDE (scpc_pkg::ADC_DIVIDE),
      .W      (5)
   ) u_adc_div (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .en_i   (adc_src_pll_i),
      .tick_o (adc_tick)
   );

   // one system tick drives cpu, io and flash; cpu and flash halt in sleep
   // adc runs on the fixed divider of the raw pll clock
   // override keeps the pll running in power-save and power-down
   // slow osc also kept alive in power-down by the override
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cpu_clk_en_o      <= 1'b0;
         io_clk_en_o       <= 1'b0;
         flash_clk_en_o    <= 1'b0;
         adc_clk_en_o      <= 1'b0;
         pll_run_o         <= 1'b1;
         slow_osc_run_o    <= 1'b1;
         lock_change_irq_o <= 1'b0;
      end else begin
         cpu_clk_en_o      <= sys_tick & ~sleep_i;
         flash_clk_en_o    <= sys_tick & ~sleep_i;
         io_clk_en_o       <= sys_tick & ~in_pdown & ~in_psave;
         adc_clk_en_o      <= adc_tick;
         pll_run_o         <= pll_sleep_override | ~(in_pdown | (in_psave & ~adc_src_pll_i));
         slow_osc_run_o    <= pll_sleep_override | ~in_pdown;
         // request only while enabled and flagged
         lock_change_irq_o <= lock_change_irq_enable & lock_change_flag;
      end
   end

   // toggle on each cpu tick gives cpu clock over two
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         clock_out_pin_o <= 1'b0;
      end else if (!clock_out_enable) begin
         clock_out_pin_o <= 1'b0;
      end else if (sys_tick && !sleep_i) begin
         clock_out_pin_o <= ~clock_out_pin_o;
      end
   end

   // ---------------- checks ----------------
   // base ticks seen since the last system tick
   logic [2:0] base_gap;
   logic [4:0] adc_gap;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         base_gap <= 3'h0;
         adc_gap  <= 5'h1f;
      end else begin
         if (sys_tick) begin
            base_gap <= 3'h0;
         end else if (base_tick) begin
            base_gap <= base_gap + 3'h1;
         end
         // saturated means unknown phase: the first period after enabling is not timed
         if (adc_tick) begin
            adc_gap <= 5'h00;
         end else if (!adc_src_pll_i) begin
            adc_gap <= 5'h1f;
         end else if (adc_gap != 5'h1f) begin
            adc_gap <= adc_gap + 5'h01;
         end
      end
   end

   // every system period is exactly one active-ratio period
   a_tick_spacing: assert property (@(posedge clk_i) disable iff (rst_i)
      sys_tick && fuse_done |-> base_gap == div_mask)
      else $error("system tick spacing does not match the ratio");

   // window opens only from the exact unlock value
   a_pce_opens: assert property (@(posedge clk_i) disable iff (rst_i)
      $rose(change_en) |-> $past(wr_clk) && $past(wdat) == scpc_pkg::PRESC_UNLOCK_VAL)
      else $error("change enable set without unlock write");

   // window closes within five slowest system periods
   a_pce_timeout: assert property (@(posedge clk_i) disable iff (rst_i)
      $rose(change_en) |-> ##[1:80] !change_en)
      else $error("change enable stayed open too long");

   // select changes only through an open window
   a_sel_guarded: assert property (@(posedge clk_i) disable iff (rst_i)
      fuse_done && $past(fuse_done) && $changed(presc_sel) |-> $past(change_en))
      else $error("select changed without change enable");

   // lock edge raises the flag one cycle later, three cycles after the pin changes
   a_flag_sets: assert property (@(posedge clk_i) disable iff (rst_i)
      lock_edge |=> lock_change_flag)
      else $error("lock edge missed");

   // request follows enable and flag by one cycle
   a_irq_gate: assert property (@(posedge clk_i) disable iff (rst_i)
      lock_change_irq_o |-> $past(lock_change_irq_enable) && $past(lock_change_flag))
      else $error("interrupt without enable and flag");

   a_clkout_sleep: assert property (@(posedge clk_i) disable iff (rst_i)
      $past(sleep_i) && $past(clock_out_enable) |-> $stable(clock_out_pin_o))
      else $error("clock out toggled during sleep");

   // adc ticks exactly 28 clocks apart
   a_adc_period: assert property (@(posedge clk_i) disable iff (rst_i)
      adc_tick && $past(adc_src_pll_i, 28) && adc_gap != 5'h1f |-> adc_gap == 5'd27)
      else $error("adc tick spacing wrong");

   // trims change only inside the unlock window
   a_trim_guard: assert property (@(posedge clk_i) disable iff (rst_i)
      $changed(trim_value_a_o) || $changed(trim_value_b_o) |-> $past(trim_open))
      else $error("trim changed while locked");

   c_unlock: cover property (@(posedge clk_i) disable iff (rst_i) $rose(change_en));
   c_switch: cover property (@(posedge clk_i) disable iff (rst_i) switch_now);
   c_flag:   cover property (@(posedge clk_i) disable iff (rst_i) $rose(lock_change_irq_o));
   c_trim:   cover property (@(posedge clk_i) disable iff (rst_i) trim_wr_a);
endmodule : scpc_ctrl

// ---- rtl/scpc_pkg.sv ----
// constants of the system clock prescaler controller
package scpc_pkg;
   // register indices; the byte address is four times the index
   localparam logic [7:0] IDX_MCU_CONTROL   = 8'h55;
   localparam logic [7:0] IDX_CLOCK_PRESC   = 8'h61;
   localparam logic [7:0] IDX_TRIM_A        = 8'h66;
   localparam logic [7:0] IDX_TRIM_B        = 8'h67;
   localparam logic [7:0] IDX_TRIM_UNLOCK   = 8'h68;
   localparam logic [7:0] IDX_PLL_CTRL_STAT = 8'hd8;

   // field positions
   localparam int BIT_CLOCK_OUT_ENABLE  = 5;
   localparam int BIT_PRESC_CHANGE_EN   = 7;
   localparam int BIT_PLL_SLEEP_OVR     = 5;
   localparam int BIT_PLL_LOCK          = 4;
   localparam int BIT_LOCK_CHANGE_FLAG  = 1;
   localparam int BIT_LOCK_CHANGE_IE    = 0;

   // writable masks; other bits read zero, except the pll lock status and lock change flag
   localparam logic [7:0] MASK_MCU_CONTROL = 8'h20;
   localparam logic [7:0] MASK_PLL_CTRL    = 8'h21;

   // reset values and keys
   localparam logic [7:0] RST_MCU_CONTROL  = 8'h00;
   localparam logic [1:0] SEL_DIV1         = 2'h0;
   localparam logic [1:0] SEL_DIV8         = 2'h3;
   localparam logic [7:0] PRESC_UNLOCK_VAL = 8'h80;
   localparam logic [7:0] TRIM_UNLOCK_KEY  = 8'hd8;

   // timing counts: change window in system clock cycles, adc divide in pll clock cycles
   localparam logic [2:0] CHANGE_WINDOW_CYC = 3'h4;
   localparam int         ADC_DIVIDE        = 28;

   // sleep mode encoding on sleep_mode_i
   typedef enum logic [1:0] {
      SCPC_IDLE       = 2'b00,
      SCPC_RESERVED   = 2'b01,
      SCPC_POWER_DOWN = 2'b10,
      SCPC_POWER_SAVE = 2'b11
   } scpc_sleep_t;
endpackage : scpc_pkg

// ---- rtl/scpc_tick_div.sv ----
// fixed ratio divider producing a one-cycle tick every DIVIDE enables
`timescale 1ns/1ps
module scpc_tick_div #(
   parameter int DIVIDE = 28,
   parameter int W      = 5
) (
   // clock and reset
   input  wire logic clk_i,
   input  wire logic rst_i,
   // enable in, tick out
   input  wire logic en_i,
   output logic      tick_o
);
   localparam logic [W-1:0] LAST = W'(DIVIDE - 1);

   logic [W-1:0] count;
   wire          at_last = (count == LAST);

   // count enables, wrap at the last one
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         count  <= '0;
         tick_o <= 1'b0;
      end else begin
         tick_o <= en_i & at_last;
         if (en_i) begin
            count <= at_last ? '0 : count + W'(1);
         end
      end
   end
endmodule : scpc_tick_div
